// ===== irq_prio_params.svh
// Constants for the eight-source interrupt prioritizer
`ifndef IRQ_PRIO_PARAMS_SVH
`define IRQ_PRIO_PARAMS_SVH
`define NUM_SOURCES 8
`define NUM_LEVELS 4
`define VEC_ADDR_W 16
`define VEC_BASE 16'h0003
`define VEC_STRIDE 16'h0008
`define SRC_EXT0 0
`define SRC_TIMER0 1
`define SRC_EXT1 2
`define SRC_TIMER1 3
`define SRC_SERIAL 4
`define SRC_TIMER2 5
`define SRC_EXT2 6
`define SRC_EXT3 7
`endif

// ===== irq_prio_pkg.sv
// Types for the eight-source interrupt prioritizer
package irq_prio_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_VECTOR
    } irq_state_t;

    // Raw request flags and external edge-mode bits from the peripherals
    typedef struct packed {
        logic [3:0] ext_flag;
        logic [3:0] ext_edge_mode;
        logic timer0_overflow_flag;
        logic timer1_overflow_flag;
        logic timer2_overflow_flag;
        logic timer2_external_flag;
        logic serial_receive_done;
        logic serial_transmit_done;
    } irq_sources_t;

    // Hardware clear strobes returned to the peripherals
    typedef struct packed {
        logic [3:0] ext_clear;
        logic timer0_clear;
        logic timer1_clear;
    } irq_clears_t;

    typedef struct packed {
        irq_state_t state;
        logic [3:0] active_levels;
        logic vector_req;
        logic [15:0] vector_addr;
        logic [2:0] vector_src;
        irq_clears_t clears;
    } irq_regs_t;
endpackage

// ===== irq_level_pick.sv
// Priority level and poll-order selector for pending sources
`timescale 1ns/1ps
`include "irq_prio_params.svh"
module irq_level_pick
    import irq_prio_pkg::*;
#(
    parameter int N = `NUM_SOURCES
) (
    input wire logic [N-1:0] pending,
    input wire logic [N-1:0] prio_hi,
    input wire logic [N-1:0] prio_lo,
    output logic found,
    output logic [1:0] level,
    output logic [$clog2(N)-1:0] index
);
    // Elaboration guard: a single source leaves nothing to arbitrate
    if (N < 2) begin : g_bad_count
        $error("irq_level_pick needs at least two sources");
    end

    // Highest level wins; lower index wins a tie
    always_comb begin
        logic [1:0] lv;
        lv = 2'h0;
        found = 1'b0;
        level = 2'h0;
        index = '0;
        for (int i = 0; i < N; i++) begin
            lv = {prio_hi[i], prio_lo[i]};
            if (pending[i] && (!found || lv > level)) begin
                found = 1'b1;
                level = lv;
                index = i[$clog2(N)-1:0];
            end
        end
    end
endmodule

// ===== irq_prioritizer.sv
// Eight-source interrupt prioritizer with vectoring and nesting
`timescale 1ns/1ps
`include "irq_prio_params.svh"
// How it works
// - Eight sources exist, each with its own fixed vector address.
// - Each source has an enable bit, and a cleared bit blocks it.
// - The global enable bit blocks every source while it is clear.
// - Priority is two bits, high bit and low bit, from level 0 to level 3.
// - A routine in service is never preempted by a lower level request.
// - Of simultaneous requests, the higher level goes first.
// - Equal levels are resolved by fixed poll order ext0 first, ext3 last.
// - Vectors run from 0003H to 003BH, eight bytes apart in poll order.
// - The serial request is receive OR transmit done, never auto-cleared.
// - The timer 2 request is overflow OR external flag, never auto-cleared.
// - External flags are cleared on vectoring only in edge mode.
// - Timer 0 and timer 1 overflow flags are cleared on vectoring.
module irq_prioritizer
    import irq_prio_pkg::*;
#(
    parameter int N = `NUM_SOURCES
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire irq_sources_t sources,
    input wire logic global_irq_enable,
    input wire logic [7:0] source_enable_reg,
    input wire logic [7:0] priority_low_reg,
    input wire logic [7:0] priority_high_reg,
    input wire logic vector_ack,
    input wire logic irq_return,
    output logic vector_req,
    output logic [15:0] vector_addr,
    output logic [2:0] vector_src,
    output logic [3:0] active_levels,
    output irq_clears_t clears
);
    // Elaboration guard: indices and vectors are sized for eight sources
    if (N != `NUM_SOURCES) begin : g_bad_count
        $error("irq_prioritizer serves exactly eight sources");
    end

    irq_regs_t r;
    irq_regs_t next_r;
    logic [N-1:0] request;
    logic [N-1:0] pending;
    logic found;
    logic [1:0] win_level;
    logic [2:0] win_index;
    logic [1:0] cur_level;
    logic any_active;

    // Request vector in poll order
    always_comb begin
        request = '0;
        request[`SRC_EXT0] = sources.ext_flag[0];
        request[`SRC_TIMER0] = sources.timer0_overflow_flag;
        request[`SRC_EXT1] = sources.ext_flag[1];
        request[`SRC_TIMER1] = sources.timer1_overflow_flag;
        request[`SRC_SERIAL] = sources.serial_receive_done
            | sources.serial_transmit_done;
        request[`SRC_TIMER2] = sources.timer2_overflow_flag
            | sources.timer2_external_flag;
        request[`SRC_EXT2] = sources.ext_flag[2];
        request[`SRC_EXT3] = sources.ext_flag[3];
    end

    // Gate by per-source and global enables
    assign pending = request & source_enable_reg & {N{global_irq_enable}};

    irq_level_pick #(
        .N(N)
    ) u_pick (
        .pending(pending),
        .prio_hi(priority_high_reg),
        .prio_lo(priority_low_reg),
        .found(found),
        .level(win_level),
        .index(win_index)
    );

    // Highest level currently in service
    always_comb begin
        any_active = |r.active_levels;
        cur_level = 2'h0;
        for (int l = 0; l < `NUM_LEVELS; l++) begin
            if (r.active_levels[l]) begin
                cur_level = l[1:0];
            end
        end
    end

    // Arbitration, vectoring and level tracking
    always_comb begin
        next_r = r;
        next_r.clears = '0;
        case (r.state)
            ST_IDLE: begin
                // Only a strictly higher level may nest
                if (found && (!any_active || win_level > cur_level)) begin
                    next_r.state = ST_VECTOR;
                    next_r.vector_req = 1'b1;
                    next_r.vector_src = win_index;
                    next_r.vector_addr = `VEC_BASE
                        + (`VEC_STRIDE * {13'h0000, win_index});
                end else if (irq_return && any_active) begin
                    next_r.active_levels[cur_level] = 1'b0;
                end
            end
            ST_VECTOR: begin
                if (vector_ack) begin
                    next_r.state = ST_IDLE;
                    next_r.vector_req = 1'b0;
                    next_r.active_levels[{priority_high_reg[r.vector_src],
                        priority_low_reg[r.vector_src]}] = 1'b1;
                    case (r.vector_src)
                        3'(`SRC_EXT0):
                            next_r.clears.ext_clear[0] = sources.ext_edge_mode[0];
                        3'(`SRC_EXT1):
                            next_r.clears.ext_clear[1] = sources.ext_edge_mode[1];
                        3'(`SRC_EXT2):
                            next_r.clears.ext_clear[2] = sources.ext_edge_mode[2];
                        3'(`SRC_EXT3):
                            next_r.clears.ext_clear[3] = sources.ext_edge_mode[3];
                        3'(`SRC_TIMER0): next_r.clears.timer0_clear = 1'b1;
                        3'(`SRC_TIMER1): next_r.clears.timer1_clear = 1'b1;
                        default: next_r.clears = '0;
                    endcase
                end
            end
            default: begin
                next_r.state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign vector_req = r.vector_req;
    assign vector_addr = r.vector_addr;
    assign vector_src = r.vector_src;
    assign active_levels = r.active_levels;
    assign clears = r.clears;

    // Assertions
    property p_gate_global;
        @(posedge ref_clk) disable iff (!rstn)
        (r.state == ST_IDLE && !global_irq_enable) |=> !vector_req;
    endproperty
    a_gate_global: assert property (p_gate_global)
        else $error("vector without global enable");

    property p_gate_source;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(vector_req) |-> $past(source_enable_reg[win_index]);
    endproperty
    a_gate_source: assert property (p_gate_source)
        else $error("disabled source vectored");

    property p_vec_addr;
        @(posedge ref_clk) disable iff (!rstn)
        vector_req |-> vector_addr == 16'h0003 + 16'h0008 * {13'h0000, vector_src};
    endproperty
    a_vec_addr: assert property (p_vec_addr)
        else $error("wrong vector address");

    property p_ext0_first;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(vector_req) && $past(pending[0] && priority_high_reg[0] && priority_low_reg[0])
            |-> vector_src == 3'h0;
    endproperty
    a_ext0_first: assert property (p_ext0_first)
        else $error("poll order broken");

    property p_no_same_level;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(vector_req) |-> !$past(any_active) || $past(win_level) > $past(cur_level);
    endproperty
    a_no_same_level: assert property (p_no_same_level)
        else $error("preempted by equal or lower");

    property p_level_mark;
        @(posedge ref_clk) disable iff (!rstn)
        (vector_req && vector_ack) |=> active_levels != 4'h0;
    endproperty
    a_level_mark: assert property (p_level_mark)
        else $error("level not marked");

    property p_timer0_clear;
        @(posedge ref_clk) disable iff (!rstn)
        (vector_req && vector_ack && vector_src == 3'h1) |=> clears.timer0_clear;
    endproperty
    a_timer0_clear: assert property (p_timer0_clear)
        else $error("timer0 flag not cleared");

    property p_timer1_clear;
        @(posedge ref_clk) disable iff (!rstn)
        (vector_req && vector_ack && vector_src == 3'h3) |=> clears.timer1_clear;
    endproperty
    a_timer1_clear: assert property (p_timer1_clear)
        else $error("timer1 flag not cleared");

    property p_serial_noclear;
        @(posedge ref_clk) disable iff (!rstn)
        (vector_req && vector_ack && vector_src == 3'h4) |=> clears == '0;
    endproperty
    a_serial_noclear: assert property (p_serial_noclear)
        else $error("serial flag cleared");

    property p_ext_level_keep;
        @(posedge ref_clk) disable iff (!rstn)
        (vector_req && vector_ack && vector_src == 3'h2 && !sources.ext_edge_mode[1])
            |=> !clears.ext_clear[1];
    endproperty
    a_ext_level_keep: assert property (p_ext_level_keep)
        else $error("level ext cleared");

    c_vector: cover property (@(posedge ref_clk) disable iff (!rstn) vector_req && vector_ack);
    c_nest: cover property (@(posedge ref_clk) disable iff (!rstn) $countones(active_levels) == 2);
    c_return: cover property (@(posedge ref_clk) disable iff (!rstn) irq_return && any_active);
endmodule

// ===== core_model.sv
// Core-side partner: takes vectors after a chosen delay and signals returns
`timescale 1ns/1ps
module core_model (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic vector_req,
    input wire logic ret_cmd,
    input wire logic [1:0] ack_delay,
    output logic vector_ack,
    output logic irq_return
);
    int wait_cnt;
    logic req_s, ack_s, ret_s;
    // Ack held until the edge that samples it, return only with no vector open
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            vector_ack = 1'b0;
            irq_return = 1'b0;
            wait_cnt = 0;
        end else begin
            req_s = vector_req;
            ack_s = vector_ack;
            ret_s = ret_cmd;
            #1;
            irq_return = ret_s && !req_s;
            if (ack_s && req_s) begin
                vector_ack = 1'b0;
                wait_cnt = 0;
            end else if (req_s) begin
                if (wait_cnt >= ack_delay) vector_ack = 1'b1;
                else wait_cnt++;
            end
        end
    end
endmodule

// ===== tb_irq_prioritizer.sv
// Self-checking bench for the interrupt prioritizer against a reference model
`timescale 1ns/1ps
module tb_irq_prioritizer;
    import irq_prio_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    irq_sources_t sources = '0;
    logic global_irq_enable = 1'b0;
    logic [7:0] source_enable_reg = 8'h00;
    logic [7:0] priority_low_reg = 8'h00;
    logic [7:0] priority_high_reg = 8'h00;
    logic vector_ack, irq_return, vector_req;
    logic ret_cmd = 1'b0;
    logic [1:0] ack_delay = 2'h0;
    logic [15:0] vector_addr;
    logic [2:0] vector_src;
    logic [3:0] active_levels;
    irq_clears_t clears, exp_clr;
    int mismatches = 0, samples_checked = 0, act_m = 0, win, lvl, n, e, k;
    logic [31:0] rng = 32'h4c4f;
    logic [31:0] r;
    logic [7:0] pend;

    always #20 ref_clk = ~ref_clk;

    irq_prioritizer dut_u (.ref_clk(ref_clk), .rstn(rstn), .sources(sources),
        .global_irq_enable(global_irq_enable), .source_enable_reg(source_enable_reg),
        .priority_low_reg(priority_low_reg), .priority_high_reg(priority_high_reg),
        .vector_ack(vector_ack), .irq_return(irq_return), .vector_req(vector_req),
        .vector_addr(vector_addr), .vector_src(vector_src),
        .active_levels(active_levels), .clears(clears));
    core_model core_u (.ref_clk(ref_clk), .rstn(rstn), .vector_req(vector_req),
        .ret_cmd(ret_cmd), .ack_delay(ack_delay), .vector_ack(vector_ack),
        .irq_return(irq_return));

    // Xorshift source of stimulus
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task stop_test();
        $display("compared %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Reference arbitration: level above those in service, then poll order
    task pick();
        int top;
        pend = {sources.ext_flag[3], sources.ext_flag[2],
            sources.timer2_overflow_flag | sources.timer2_external_flag,
            sources.serial_receive_done | sources.serial_transmit_done,
            sources.timer1_overflow_flag, sources.ext_flag[1],
            sources.timer0_overflow_flag, sources.ext_flag[0]};
        top = -1;
        for (int l = 0; l < 4; l++) if (act_m[l]) top = l;
        win = -1;
        for (int l = top + 1; l < 4; l++)
            for (int i = 7; i >= 0; i--)
                if (pend[i] && source_enable_reg[i] && global_irq_enable &&
                    int'({priority_high_reg[i], priority_low_reg[i]}) == l) begin
                    win = i;
                    lvl = l;
                end
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        #1 rstn = 1'b1;
        for (n = 0; n < 80; n++) begin
            @(posedge ref_clk);
            #1;
            r = xs();
            sources = r[13:0];
            r = xs();
            source_enable_reg = r[7:0];
            priority_low_reg = r[15:8];
            priority_high_reg = r[23:16];
            global_irq_enable = r[25:24] != 2'h0;
            ack_delay = r[27:26];
            pick();
            if (win < 0) begin
                repeat (4) @(posedge ref_clk);
                #1 check("vector_req", vector_req, 16'h0);
            end else begin
                e = (win == 0) ? 0 : (win == 2) ? 1 : (win == 6) ? 2 : (win == 7) ? 3 : -1;
                exp_clr = '0;
                if (e >= 0) exp_clr.ext_clear[e] = sources.ext_edge_mode[e];
                exp_clr.timer0_clear = win == 1;
                exp_clr.timer1_clear = win == 3;
                for (k = 0; k < 20 && !(vector_req === 1'b1 && vector_ack === 1'b1); k++)
                    @(negedge ref_clk);
                if (k == 20) begin
                    check("vector wait", 16'h1, 16'h0);
                    stop_test();
                end
                check("vector_src", 16'(vector_src), 16'(win));
                check("vector_addr", vector_addr, 16'h0003 + 16'(8 * win));
                @(posedge ref_clk);
                #1;
                act_m = act_m | (1 << lvl);
                check("clears", 16'(clears), 16'(exp_clr));
                check("vector_req low", vector_req, 16'h0);
            end
            check("active_levels", 16'(active_levels), 16'(act_m));
            sources = '0;
            if (r[28] && act_m != 0) begin
                @(posedge ref_clk);
                #1 ret_cmd = 1'b1;
                @(posedge ref_clk);
                #1 ret_cmd = 1'b0;
                repeat (2) @(posedge ref_clk);
                #1;
                for (int l = 3; l >= 0; l--)
                    if (act_m[l]) begin
                        act_m[l] = 1'b0;
                        break;
                    end
                check("active after return", 16'(active_levels), 16'(act_m));
            end
            $display("test %0d done", n);
        end
        stop_test();
    end
endmodule
